// ==== lsc_map.svh ====
/*
  Constants of the light sensor command link: bus address, command codes,
  field positions, reset values and timing.
  Assumes inclusion by bare name from both link ends and the checker.
*/
`ifndef LSC_MAP_SVH
`define LSC_MAP_SVH

// Bus address and command codes
`define LSC_DEV_ADDR      7'h29
`define LSC_CMD_RESET     8'h80
`define LSC_CMD_ACTIVATE  8'h04
`define LSC_CMD_START     8'h08
`define LSC_CMD_STOP      8'h30

// Field positions
`define LSC_SHUT_BIT      7
`define LSC_VALID_BIT     15

// Reset and limit values
`define LSC_RESULT_CLR    16'h0000
`define LSC_COUNT_CLR     15'h0000
`define LSC_COUNT_ONE     15'h0001
`define LSC_COUNT_MAX     15'h7fff
`define LSC_BITS_PER_BYTE 4'h8
`define LSC_BIT_ONE       4'h1
`define LSC_BYTE_CLR      8'h00
`define LSC_WORD_CLR      16'h0000

// Timing
`define LSC_CLK_HZ        50000000
`define LSC_SCL_HZ        100000
`define LSC_QUARTERS      4

`endif

// ==== lsc_pkg.sv ====
/*
  Types of the light sensor command link: state enums and state structs
  of both link ends.
  Assumes lsc_map.svh is reachable by bare name.
*/
package lsc_pkg;

  typedef enum logic [2:0] {
    P_IDLE  = 3'h0,
    P_ADDR  = 3'h1,
    P_AACK  = 3'h2,
    P_WDATA = 3'h3,
    P_WACK  = 3'h4,
    P_RDATA = 3'h5,
    P_RACK  = 3'h6
  } lsc_dev_phase_e;

  typedef enum logic [1:0] {
    H_IDLE  = 2'h0,
    H_START = 2'h1,
    H_BIT   = 2'h2,
    H_STOP  = 2'h3
  } lsc_host_st_e;

  typedef struct packed {
    logic [1:0]     scl_sync;
    logic           scl_prev;
    logic [1:0]     sda_sync;
    logic           sda_prev;
    logic [1:0]     lp_sync;
    logic           lp_prev;
    lsc_dev_phase_e phase;
    logic [3:0]     bit_cnt;
    logic [7:0]     shreg;
    logic           rw;
    logic           m_ack;
    logic           byte_sel;
    logic           sda_oe_n;
    logic [7:0]     cmd;
    logic           active;
    logic           integ;
    logic [14:0]    count;
    logic [15:0]    result;
  } lsc_dev_s;

  typedef struct packed {
    lsc_host_st_e   st;
    logic [1:0]     q;
    logic [15:0]    tick;
    logic [3:0]     bitn;
    logic [1:0]     byten;
    logic [7:0]     shreg;
    logic [7:0]     tx_cmd;
    logic           rd;
    logic           word;
    logic [15:0]    rx;
    logic [1:0]     sda_sync;
    logic           scl_oe_n;
    logic           sda_oe_n;
    logic           busy;
    logic           done;
    logic           err;
    logic [15:0]    rd_data;
  } lsc_host_s;

endpackage : lsc_pkg

// ==== lsc_if.sv ====
/*
  Two-wire link between bus master and light sensor, open-drain wires.
  Assumes each end drives its output low and enables it with a low enable.
*/
interface lsc_if;

  // Master side pins
  logic scl_m_o;
  logic scl_m_oe_n;
  logic sda_m_o;
  logic sda_m_oe_n;
  // Sensor side pins
  logic sda_s_o;
  logic sda_s_oe_n;
  // Resolved wire levels with pull-ups
  logic scl;
  logic sda;

  assign scl = scl_m_oe_n | scl_m_o;
  assign sda = (sda_m_oe_n | sda_m_o) & (sda_s_oe_n | sda_s_o);

  modport host (
    output scl_m_o,
    output scl_m_oe_n,
    output sda_m_o,
    output sda_m_oe_n,
    input  scl,
    input  sda
  );

  modport dev (
    output sda_s_o,
    output sda_s_oe_n,
    input  scl,
    input  sda
  );

endinterface : lsc_if

// ==== lsc_dev.sv ====
/*
  Light sensor end: two-wire slave with command register, integration
  control and 16-bit result register.
  Assumes REF_CLK far faster than the link clock; SCL, SDA and LIGHT_PULSE
  are asynchronous and pass two flip-flops first.
*/
`include "lsc_map.svh"

module lsc_dev (
  // System
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  // Two-wire link
  lsc_if.dev               BUS,
  // Light-to-frequency input
  input  wire logic        LIGHT_PULSE,
  // Status
  output logic             ACTIVE,
  output logic             INTEGRATING,
  output logic [7:0]       CMD,
  output logic [15:0]      RESULT
);

  localparam lsc_pkg::lsc_dev_s DEV_RST = '{
    scl_sync: 2'h3,
    scl_prev: 1'b1,
    sda_sync: 2'h3,
    sda_prev: 1'b1,
    lp_sync:  2'h0,
    lp_prev:  1'b0,
    phase:    lsc_pkg::P_IDLE,
    bit_cnt:  4'h0,
    shreg:    `LSC_BYTE_CLR,
    rw:       1'b0,
    m_ack:    1'b0,
    byte_sel: 1'b0,
    sda_oe_n: 1'b1,
    cmd:      `LSC_CMD_RESET,
    active:   1'b0,
    integ:    1'b0,
    count:    `LSC_COUNT_CLR,
    result:   `LSC_RESULT_CLR
  };

  lsc_pkg::lsc_dev_s s;
  lsc_pkg::lsc_dev_s next_s;

  logic              scl_rise;
  logic              scl_fall;
  logic              start_det;
  logic              stop_det;
  logic              lp_rise;
  logic [7:0]        out_byte;

  function automatic logic rose(input logic now, input logic prev);
    rose = now & ~prev;
  endfunction : rose

  function automatic logic fell(input logic now, input logic prev);
    fell = ~now & prev;
  endfunction : fell

  // Byte returned on a read
  function automatic logic [7:0] read_byte(input lsc_pkg::lsc_dev_s st,
                                           input logic sel);
    if (st.cmd[`LSC_SHUT_BIT]) begin
      read_byte = st.cmd;
    end else if (sel) begin
      read_byte = st.result[7:0];
    end else begin
      read_byte = st.result[15:8];
    end
  endfunction : read_byte

  assign scl_rise  = rose(s.scl_sync[1], s.scl_prev);
  assign scl_fall  = fell(s.scl_sync[1], s.scl_prev);
  assign start_det = s.scl_sync[1] & s.scl_prev &
                     fell(s.sda_sync[1], s.sda_prev);
  assign stop_det  = s.scl_sync[1] & s.scl_prev &
                     rose(s.sda_sync[1], s.sda_prev);
  assign lp_rise   = rose(s.lp_sync[1], s.lp_prev);

  always_comb begin
    next_s = s;
    out_byte = read_byte(s, ~s.byte_sel);
    next_s.scl_sync = {s.scl_sync[0], BUS.scl};
    next_s.scl_prev = s.scl_sync[1];
    next_s.sda_sync = {s.sda_sync[0], BUS.sda};
    next_s.sda_prev = s.sda_sync[1];
    next_s.lp_sync  = {s.lp_sync[0], LIGHT_PULSE};
    next_s.lp_prev  = s.lp_sync[1];

    // Count light pulses while integrating, saturating
    if (s.integ && lp_rise && s.count != `LSC_COUNT_MAX) begin
      next_s.count = s.count + `LSC_COUNT_ONE;
    end

    if (start_det) begin
      next_s.phase    = lsc_pkg::P_ADDR;
      next_s.bit_cnt  = 4'h0;
      next_s.sda_oe_n = 1'b1;
    end else if (stop_det) begin
      next_s.phase    = lsc_pkg::P_IDLE;
      next_s.sda_oe_n = 1'b1;
    end else if (scl_rise) begin
      case (s.phase)
        lsc_pkg::P_ADDR, lsc_pkg::P_WDATA: begin
          next_s.shreg   = {s.shreg[6:0], s.sda_sync[1]};
          next_s.bit_cnt = s.bit_cnt + `LSC_BIT_ONE;
        end
        lsc_pkg::P_RDATA: begin
          next_s.bit_cnt = s.bit_cnt + `LSC_BIT_ONE;
        end
        lsc_pkg::P_RACK: begin
          next_s.m_ack = ~s.sda_sync[1];
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (s.phase)
        lsc_pkg::P_ADDR: begin
          if (s.bit_cnt == `LSC_BITS_PER_BYTE) begin
            if (s.shreg[7:1] == `LSC_DEV_ADDR) begin
              next_s.sda_oe_n = 1'b0;
              next_s.rw       = s.shreg[0];
              next_s.phase    = lsc_pkg::P_AACK;
            end else begin
              next_s.phase = lsc_pkg::P_IDLE;
            end
          end
        end
        lsc_pkg::P_AACK: begin
          next_s.bit_cnt = 4'h0;
          if (s.rw) begin
            next_s.byte_sel = 1'b0;
            out_byte        = read_byte(s, 1'b0);
            next_s.sda_oe_n = out_byte[7];
            next_s.shreg    = {out_byte[6:0], 1'b0};
            next_s.phase    = lsc_pkg::P_RDATA;
          end else begin
            next_s.sda_oe_n = 1'b1;
            next_s.phase    = lsc_pkg::P_WDATA;
          end
        end
        lsc_pkg::P_WDATA: begin
          if (s.bit_cnt == `LSC_BITS_PER_BYTE) begin
            next_s.sda_oe_n = 1'b0;
            next_s.phase    = lsc_pkg::P_WACK;
            if (s.shreg[`LSC_SHUT_BIT]) begin
              next_s.cmd    = s.shreg;
              next_s.active = 1'b0;
              next_s.integ  = 1'b0;
            end else if (s.shreg == `LSC_CMD_ACTIVATE) begin
              next_s.cmd    = s.shreg;
              next_s.active = 1'b1;
            end else if (s.shreg == `LSC_CMD_START && s.active) begin
              next_s.cmd    = s.shreg;
              next_s.result = `LSC_RESULT_CLR;
              next_s.count  = `LSC_COUNT_CLR;
              next_s.integ  = 1'b1;
            end else if (s.shreg == `LSC_CMD_STOP && s.integ) begin
              next_s.cmd    = s.shreg;
              next_s.integ  = 1'b0;
              next_s.result = {1'b1, s.count};
            end
            // Any other byte leaves state alone
          end
        end
        lsc_pkg::P_WACK: begin
          next_s.sda_oe_n = 1'b1;
          next_s.bit_cnt  = 4'h0;
          next_s.phase    = lsc_pkg::P_WDATA;
        end
        lsc_pkg::P_RDATA: begin
          if (s.bit_cnt == `LSC_BITS_PER_BYTE) begin
            next_s.sda_oe_n = 1'b1;
            next_s.m_ack    = 1'b0;
            next_s.phase    = lsc_pkg::P_RACK;
          end else begin
            next_s.sda_oe_n = s.shreg[7];
            next_s.shreg    = {s.shreg[6:0], 1'b0};
          end
        end
        lsc_pkg::P_RACK: begin
          if (s.m_ack) begin
            next_s.byte_sel = ~s.byte_sel;
            next_s.bit_cnt  = 4'h0;
            next_s.sda_oe_n = out_byte[7];
            next_s.shreg    = {out_byte[6:0], 1'b0};
            next_s.phase    = lsc_pkg::P_RDATA;
          end else begin
            next_s.phase = lsc_pkg::P_IDLE;
          end
        end
        default: begin
          next_s.sda_oe_n = 1'b1;
        end
      endcase
    end
  end

  // Result changes only on start, stop and reset, never on a read
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      s <= DEV_RST;
    end else begin
      s <= next_s;
    end
  end

  assign BUS.sda_s_o    = 1'b0;
  assign BUS.sda_s_oe_n = s.sda_oe_n;
  assign ACTIVE         = s.active;
  assign INTEGRATING    = s.integ;
  assign CMD            = s.cmd;
  assign RESULT         = s.result;

endmodule : lsc_dev

// ==== lsc_host.sv ====
/*
  Bus master end: sends single command bytes and performs one- or
  two-byte reads from the light sensor, making the link clock by division.
  Assumes a sensor at the fixed address; no clock stretching by the sensor.
*/
`include "lsc_map.svh"

module lsc_host #(
  parameter int QUARTER = `LSC_CLK_HZ / (`LSC_QUARTERS * `LSC_SCL_HZ)
) (
  // System
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  // Two-wire link
  lsc_if.host              BUS,
  // Requests
  input  wire logic        CMD_REQ,
  input  wire logic [7:0]  CMD_BYTE,
  input  wire logic        RD_REQ,
  input  wire logic        RD_WORD,
  // Answers
  output logic             BUSY,
  output logic             DONE,
  output logic             NACK_ERR,
  output logic [15:0]      RD_DATA
);

  localparam logic [15:0] QUARTER_M1 = 16'(QUARTER - 1);

  localparam lsc_pkg::lsc_host_s HOST_RST = '{
    st:       lsc_pkg::H_IDLE,
    q:        2'h0,
    tick:     16'h0000,
    bitn:     4'h0,
    byten:    2'h0,
    shreg:    `LSC_BYTE_CLR,
    tx_cmd:   `LSC_BYTE_CLR,
    rd:       1'b0,
    word:     1'b0,
    rx:       `LSC_WORD_CLR,
    sda_sync: 2'h3,
    scl_oe_n: 1'b1,
    sda_oe_n: 1'b1,
    busy:     1'b0,
    done:     1'b0,
    err:      1'b0,
    rd_data:  `LSC_WORD_CLR
  };

  lsc_pkg::lsc_host_s s;
  lsc_pkg::lsc_host_s next_s;

  logic              tx;
  logic              last;

  // Sending the address byte or a command byte
  assign tx   = (s.byten == 2'h0) | ~s.rd;
  // Last byte of a read gets NACK
  assign last = s.rd & (s.byten == (s.word ? 2'h2 : 2'h1));

  always_comb begin
    next_s = s;
    next_s.sda_sync = {s.sda_sync[0], BUS.sda};
    next_s.done = 1'b0;
    if (s.st == lsc_pkg::H_IDLE) begin
      if (CMD_REQ || RD_REQ) begin
        next_s.st     = lsc_pkg::H_START;
        next_s.busy   = 1'b1;
        next_s.err    = 1'b0;
        next_s.rd     = ~CMD_REQ;
        next_s.word   = RD_WORD;
        next_s.tx_cmd = CMD_BYTE;
        next_s.shreg  = {`LSC_DEV_ADDR, ~CMD_REQ};
        next_s.rx     = `LSC_WORD_CLR;
        next_s.q      = 2'h0;
        next_s.tick   = 16'h0000;
      end
    end else if (s.tick != QUARTER_M1) begin
      next_s.tick = s.tick + 16'h0001;
    end else begin
      next_s.tick = 16'h0000;
      next_s.q    = s.q + 2'h1;
      case (s.st)
        lsc_pkg::H_START: begin
          if (s.q == 2'h0) begin
            next_s.sda_oe_n = 1'b0;
          end else begin
            next_s.scl_oe_n = 1'b0;
            next_s.st       = lsc_pkg::H_BIT;
            next_s.q        = 2'h0;
            next_s.bitn     = 4'h0;
            next_s.byten    = 2'h0;
          end
        end
        lsc_pkg::H_BIT: begin
          case (s.q)
            2'h0: begin
              if (s.bitn != `LSC_BITS_PER_BYTE) begin
                next_s.sda_oe_n = tx ? s.shreg[7] : 1'b1;
                next_s.shreg    = {s.shreg[6:0], 1'b0};
              end else begin
                next_s.sda_oe_n = tx | last;
              end
            end
            2'h1: begin
              next_s.scl_oe_n = 1'b1;
            end
            2'h2: begin
              if (s.bitn != `LSC_BITS_PER_BYTE && !tx) begin
                next_s.rx = {s.rx[14:0], s.sda_sync[1]};
              end else if (s.bitn == `LSC_BITS_PER_BYTE && tx &&
                           s.sda_sync[1]) begin
                next_s.err = 1'b1;
              end
            end
            default: begin
              next_s.scl_oe_n = 1'b0;
              if (s.bitn == `LSC_BITS_PER_BYTE) begin
                next_s.bitn = 4'h0;
                if (s.err || last || (!s.rd && s.byten == 2'h1)) begin
                  next_s.st = lsc_pkg::H_STOP;
                end else begin
                  next_s.byten = s.byten + 2'h1;
                  next_s.shreg = s.tx_cmd;
                end
              end else begin
                next_s.bitn = s.bitn + `LSC_BIT_ONE;
              end
            end
          endcase
        end
        lsc_pkg::H_STOP: begin
          case (s.q)
            2'h0: next_s.sda_oe_n = 1'b0;
            2'h1: next_s.scl_oe_n = 1'b1;
            2'h2: next_s.sda_oe_n = 1'b1;
            default: begin
              next_s.st      = lsc_pkg::H_IDLE;
              next_s.busy    = 1'b0;
              next_s.done    = 1'b1;
              next_s.rd_data = s.rx;
            end
          endcase
        end
        default: begin
          next_s.st = lsc_pkg::H_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      s <= HOST_RST;
    end else begin
      s <= next_s;
    end
  end

  assign BUS.scl_m_o    = 1'b0;
  assign BUS.sda_m_o    = 1'b0;
  assign BUS.scl_m_oe_n = s.scl_oe_n;
  assign BUS.sda_m_oe_n = s.sda_oe_n;
  assign BUSY           = s.busy;
  assign DONE           = s.done;
  assign NACK_ERR       = s.err;
  assign RD_DATA        = s.rd_data;

endmodule : lsc_host

// ==== lsc_asserts.sv ====
/*
  Checker of the two-wire link joining the host end and the sensor end.
  Assumes a host QUARTER of 8 and a place beside the link in the bench.
*/
`include "lsc_map.svh"

module lsc_asserts (
  // System
  input wire logic       REF_CLK,
  input wire logic       RST_N,
  // Link
  input wire logic       scl,
  input wire logic       sda,
  input wire logic       sda_m_oe_n,
  input wire logic       sda_s_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       scl_q;
  logic       sda_q;
  logic [3:0] nrise;
  logic [7:0] abyte;
  logic       start_ev;
  logic       stop_ev;
  logic       addr_ok;

  assign start_ev = scl & scl_q & sda_q & ~sda;
  assign stop_ev  = scl & scl_q & ~sda_q & sda;
  assign addr_ok  = (abyte[7:1] == `LSC_DEV_ADDR);

  // Counts SCL rises of a frame and keeps its first byte
  always_ff @(posedge REF_CLK) begin
    scl_q <= scl;
    sda_q <= sda;
    if (!RST_N || start_ev || stop_ev) begin
      nrise <= 4'h0;
      abyte <= 8'h00;
    end else if (scl && !scl_q && nrise != 4'hf) begin
      nrise <= nrise + 4'h1;
      if (nrise < 4'h8) begin
        abyte <= {abyte[6:0], sda};
      end
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);

  a_sens_sda_change: assert property (
    $changed(sda_s_oe_n) |-> !scl) else $error("sensor moved SDA in high");
  a_scl_high_hold: assert property (
    $rose(scl) |-> scl [*8]) else $error("SCL high too short");
  a_scl_low_hold: assert property (
    $fell(scl) |-> (!scl) [*8]) else $error("SCL low too short");
  a_host_data_hold: assert property (
    $rose(scl) |-> $stable(sda_m_oe_n) [*4]) else $error("host SDA moved");
  a_addr_ack_drive: assert property (
    $fell(scl) && nrise == 4'h8 && addr_ok |-> ##[1:8] !sda_s_oe_n)
    else $error("no address ACK");
  a_ack_bit_hold: assert property (
    $fell(sda_s_oe_n) && nrise == 4'h8 |-> (!sda_s_oe_n) [*8])
    else $error("ACK released early");
  a_start_addr_quiet: assert property (
    start_ev |-> ##1 sda_s_oe_n [*8]) else $error("sensor drove address");
  a_stop_bus_free: assert property (
    stop_ev |-> ##1 (scl && sda) [*6]) else $error("bus reused too soon");

  cover property ($fell(scl) && nrise == 4'h8 && addr_ok);
  cover property ($changed(sda_s_oe_n) && nrise > 4'h9);
  cover property (stop_ev);
endmodule : lsc_asserts

// ==== testbench.sv ====
/*
  Self-checking bench: host end and sensor end joined by one link, and a
  second sensor end driven bit by bit from the bench.
  Assumes the design files and lsc_map.svh are compiled first.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk;
  logic        rst_n;
  logic        cmd_req;
  logic [7:0]  cmd_byte;
  logic        rd_req;
  logic        rd_word;
  logic        busy;
  logic        done;
  logic        nack_err;
  logic [15:0] rd_data;
  logic        light;
  logic        active;
  logic        integ;
  logic [7:0]  cmd;
  logic [15:0] result;
  logic [7:0]  cmd2;
  int          fail_count;
  int          n_checks;
  int          cnts[3] = '{0, 258, 5};

  lsc_if bus ();
  lsc_if bus2 ();

  lsc_host #(.QUARTER(8)) lsc_host_i (
    .REF_CLK(ref_clk), .RST_N(rst_n), .BUS(bus), .CMD_REQ(cmd_req),
    .CMD_BYTE(cmd_byte), .RD_REQ(rd_req), .RD_WORD(rd_word), .BUSY(busy),
    .DONE(done), .NACK_ERR(nack_err), .RD_DATA(rd_data));
  lsc_dev lsc_dev_i (
    .REF_CLK(ref_clk), .RST_N(rst_n), .BUS(bus), .LIGHT_PULSE(light),
    .ACTIVE(active), .INTEGRATING(integ), .CMD(cmd), .RESULT(result));
  lsc_dev lsc_dev_i2 (
    .REF_CLK(ref_clk), .RST_N(rst_n), .BUS(bus2), .LIGHT_PULSE(1'b0),
    .ACTIVE(), .INTEGRATING(), .CMD(cmd2), .RESULT());
  lsc_asserts lsc_asserts_i (
    .REF_CLK(ref_clk), .RST_N(rst_n), .scl(bus.scl), .sda(bus.sda),
    .sda_m_oe_n(bus.sda_m_oe_n), .sda_s_oe_n(bus.sda_s_oe_n));

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic q8();
    repeat (8) @(posedge ref_clk);
    #1;
  endtask : q8

  // One host transfer: write byte, or read of one or two bytes
  task automatic xfer(input logic rd, input logic wd, input logic [7:0] b);
    int k;
    @(posedge ref_clk);
    #1;
    cmd_req = !rd;
    rd_req = rd;
    rd_word = wd;
    cmd_byte = b;
    @(posedge ref_clk);
    #1;
    cmd_req = 1'b0;
    rd_req = 1'b0;
    chk({15'h0000, busy}, 16'h0001);
    k = 0;
    while (done !== 1'b1 && k < 3000) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    if (k >= 3000) begin
      fail_count++;
      $display("MISMATCH %0t transfer timeout", $time);
      end_of_test();
    end
    chk({15'h0000, nack_err}, 16'h0000);
    chk({14'h0000, busy, done}, 16'h0001);
  endtask : xfer

  task automatic pulses(input int n);
    repeat (n) begin
      light = 1'b1;
      repeat (4) @(posedge ref_clk);
      #1;
      light = 1'b0;
      repeat (4) @(posedge ref_clk);
      #1;
    end
  endtask : pulses

  // One bit on the second link, bench as master
  task automatic bb_bit(input logic b, output logic got);
    bus2.sda_m_oe_n = b;
    q8();
    bus2.scl_m_oe_n = 1'b1;
    q8();
    got = bus2.sda;
    q8();
    bus2.scl_m_oe_n = 1'b0;
    q8();
  endtask : bb_bit

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (100000) @(posedge ref_clk);
    fail_count++;
    $display("MISMATCH %0t run timeout", $time);
    end_of_test();
  end

  initial begin
    logic [15:0] exp;
    logic [7:0]  ab;
    logic        got;
    fail_count = 0;
    n_checks = 0;
    exp = 16'h0000;
    rst_n = 1'b0;
    {cmd_req, rd_req, rd_word, light} = 4'h0;
    cmd_byte = 8'h00;
    {bus2.scl_m_o, bus2.sda_m_o} = 2'b00;
    {bus2.scl_m_oe_n, bus2.sda_m_oe_n} = 2'b11;
    repeat (12) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    chk({active, integ, 6'h00, cmd}, 16'h0080);
    chk(result, 16'h0000);
    xfer(1'b1, 1'b0, 8'h00);
    chk(rd_data, 16'h0080);
    xfer(1'b0, 1'b0, 8'ha5);
    chk({7'h00, active, cmd}, 16'h00a5);
    xfer(1'b1, 1'b1, 8'h00);
    chk(rd_data, 16'ha5a5);
    xfer(1'b0, 1'b0, 8'h08);
    chk({7'h00, integ, cmd}, 16'h00a5);
    xfer(1'b0, 1'b0, 8'h04);
    chk({7'h00, active, cmd}, 16'h0104);
    xfer(1'b0, 1'b0, 8'h11);
    chk({7'h00, active, cmd}, 16'h0104);
    xfer(1'b0, 1'b0, 8'h30);
    chk({15'h0000, integ}, 16'h0000);
    chk(result, 16'h0000);
    foreach (cnts[i]) begin
      xfer(1'b0, 1'b0, 8'h08);
      chk({integ, result[14:0]}, 16'h8000);
      pulses(cnts[i]);
      xfer(1'b1, 1'b1, 8'h00);
      chk({15'h0000, rd_data[15]}, 16'h0000);
      xfer(1'b0, 1'b0, 8'h30);
      exp = 16'h8000 | 16'(cnts[i]);
      chk(result, exp);
      xfer(1'b1, 1'b1, 8'h00);
      chk(rd_data, exp);
      pulses(3);
      xfer(1'b1, 1'b1, 8'h00);
      chk(rd_data, exp);
    end
    xfer(1'b0, 1'b0, 8'h80);
    chk({6'h00, active, integ, cmd}, 16'h0080);
    chk(result, exp);
    xfer(1'b1, 1'b0, 8'h00);
    chk(rd_data, 16'h0080);
    // Reset in mid-run returns the sensor to its power-up state
    rst_n = 1'b0;
    repeat (12) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    chk({6'h00, active, integ, cmd}, 16'h0080);
    chk(result, 16'h0000);
    // Neighbour addresses on the second link get no ACK
    for (int a = 0; a < 2; a++) begin
      ab = (a == 0) ? 8'h50 : 8'h54;
      bus2.sda_m_oe_n = 1'b0;
      q8();
      bus2.scl_m_oe_n = 1'b0;
      for (int j = 7; j >= 0; j--) begin
        bb_bit(ab[j], got);
      end
      bb_bit(1'b1, got);
      chk({15'h0000, got}, 16'h0001);
      bus2.sda_m_oe_n = 1'b0;
      q8();
      bus2.scl_m_oe_n = 1'b1;
      q8();
      bus2.sda_m_oe_n = 1'b1;
      q8();
      chk({8'h00, cmd2}, 16'h0080);
    end
    end_of_test();
  end
endmodule : testbench
